/* rtl/spi_master_cfg.svh */
// register offsets, field positions, reset values and counts for the spi master
// assumes a byte-wide multiplexed host bus and one system clock
//
// Overview of operation
// - low address byte selects one of five registers
// - done bit clear while shifting, set on fourteenth serial clock edge
// - contention sets error, resets engine, releases spi pins
// - busy bit follows any asserted slave select
// - pending interrupt on tx empty with start set, rx full with start clear, error
// - tx write, rx read, error clear drop pending
// - tx empty status bit also drives a pin
// - rx full status bit also drives a pin
// - status bits one and zero read zero
// - master enable low holds engine in reset
// - interrupt gate masks request, keeps pending causes
// - start with data present begins byte transfers, back to back only for phase one
// - rate code divides clock by 4 to 32
// - phase bit picks first or second data edge
// - idle level bit sets resting serial clock level
// - sample edge bit picks miso capture edge
// - mask bits drive selects, no one-hot check
// - load sets tx empty; shift needs data, start
// - finished byte copied to rx holding, full set
// - contention select input is active low
// - interrupt request low when enabled, gated and pending
`ifndef SPI_MASTER_CFG_SVH
`define SPI_MASTER_CFG_SVH
`define OFF_STATUS        8'h80
`define OFF_CONTROL       8'h84
`define OFF_SS_MASK       8'h88
`define OFF_TX_HOLD       8'h8a
`define OFF_RX_HOLD       8'h8e
`define ST_DONE           7
`define ST_ERR            6
`define ST_BUSY           5
`define ST_PEND_N         4
`define ST_TX_EMPTY       3
`define ST_RX_FULL        2
`define CR_ENABLE         7
`define CR_INT_GATE       6
`define CR_START          5
`define CR_RATE_HI        4
`define CR_RATE_LO        3
`define CR_PHASE          2
`define CR_IDLE_LVL       1
`define CR_SAMPLE_EDGE    0
`define REG_RESET         8'h00
`define PIN_RESET         22'h3f0000
`define SETUP_TICKS       4'd2
`define HOLD_TICKS        4'd4
`define GAP_TICKS         4'd2
`define LAST_EDGE         4'd15
`define DONE_EDGE         4'd13
`endif

/* rtl/spi_master_pkg.sv */
// state types for the spi master register bank
// assumes one-hot encodings are kept by the design
package spi_master_pkg;
	typedef enum logic [3:0] {
		BUS_IDLE   = 4'b0001,
		BUS_DECODE = 4'b0010,
		BUS_XFER   = 4'b0100,
		BUS_END    = 4'b1000
	} bus_state_type;
	typedef enum logic [4:0] {
		ENG_IDLE  = 5'b00001,
		ENG_SETUP = 5'b00010,
		ENG_XFER  = 5'b00100,
		ENG_HOLD  = 5'b01000,
		ENG_GAP   = 5'b10000
	} eng_state_type;
endpackage : spi_master_pkg

/* rtl/spi_master_register_bank.sv */
// spi master with host register bank and receive fifo
// assumes host bus pins and miso arrive asynchronously; pins resolved by the bench
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_cfg.svh"

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
	assign out_valid_o = (count_q != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_q[rd_ptr_q];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : byte_fifo

module spi_master_register_bank #(
	parameter logic [7:0] BASE_HI    = 8'h00,
	parameter int         FIFO_DEPTH = 8
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] addr_hi_i,
	input  wire logic [7:0] ad_i,
	output logic [7:0]      ad_o,
	output logic            ad_oe_o,
	input  wire logic       ale_n_i,
	input  wire logic       psen_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	output logic            irq_n_o,
	output logic            tx_holding_empty_o,
	output logic            rx_holding_full_o,
	output logic            sck_o,
	output logic            sck_oe_o,
	output logic            mosi_o,
	output logic            mosi_oe_o,
	input  wire logic       miso_i,
	output logic [7:0]      ss_n_o,
	output logic            ss_oe_o,
	input  wire logic       contention_n_i
);
	// pin filtering: three flops, value taken once stages two and three agree
	logic [21:0] pin_s1_q;
	logic [21:0] pin_s2_q;
	logic [21:0] pin_s3_q;
	logic [21:0] pin_q;
	logic [21:0] agree;

	assign agree = ~(pin_s2_q ^ pin_s3_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_q <= `PIN_RESET;
			pin_s2_q <= `PIN_RESET;
			pin_s3_q <= `PIN_RESET;
			pin_q    <= `PIN_RESET;
		end else begin
			pin_s1_q <= {contention_n_i, miso_i, ale_n_i, psen_n_i, rd_n_i, wr_n_i, addr_hi_i, ad_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q    <= (agree & pin_s3_q) | (~agree & pin_q);
		end
	end

	logic [7:0] ad_f;
	logic [7:0] addr_hi_f;
	logic       wr_n_f;
	logic       rd_n_f;
	logic       psen_n_f;
	logic       ale_n_f;
	logic       miso_f;
	logic       contention;

	assign ad_f       = pin_q[7:0];
	assign addr_hi_f  = pin_q[15:8];
	assign wr_n_f     = pin_q[16];
	assign rd_n_f     = pin_q[17];
	assign psen_n_f   = pin_q[18];
	assign ale_n_f    = pin_q[19];
	assign miso_f     = pin_q[20];
	assign contention = !pin_q[21];

	// host bus cycle
	spi_master_pkg::bus_state_type bus_q;
	logic [7:0] addr_lo_q;
	logic [7:0] addr_hi_q;
	logic [7:0] wdat_q;
	logic       is_wr_q;
	logic       hit;
	logic       commit;
	logic       wr_commit;
	logic       rd_commit;

	assign hit = (addr_hi_q == BASE_HI) && psen_n_f
		&& (addr_lo_q == `OFF_STATUS || addr_lo_q == `OFF_CONTROL || addr_lo_q == `OFF_SS_MASK
		|| addr_lo_q == `OFF_TX_HOLD || addr_lo_q == `OFF_RX_HOLD);
	assign commit    = (bus_q == spi_master_pkg::BUS_XFER) && rd_n_f && wr_n_f;
	assign wr_commit = commit && is_wr_q;
	assign rd_commit = commit && !is_wr_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_q     <= spi_master_pkg::BUS_IDLE;
			addr_lo_q <= `REG_RESET;
			addr_hi_q <= `REG_RESET;
			wdat_q    <= `REG_RESET;
			is_wr_q   <= 1'b0;
		end else begin
			unique case (bus_q)
				spi_master_pkg::BUS_IDLE: begin
					if (!ale_n_f) begin
						addr_lo_q <= ad_f;
						addr_hi_q <= addr_hi_f;
						bus_q     <= spi_master_pkg::BUS_DECODE;
					end
				end
				spi_master_pkg::BUS_DECODE: begin
					if (ale_n_f) begin
						bus_q <= spi_master_pkg::BUS_IDLE;
					end else if (hit && (!rd_n_f || !wr_n_f)) begin
						is_wr_q <= !wr_n_f;
						bus_q   <= spi_master_pkg::BUS_XFER;
					end
				end
				spi_master_pkg::BUS_XFER: begin
					// data is kept from the last cycle with the strobe low
					if (!wr_n_f) begin
						wdat_q <= ad_f;
					end
					if (rd_n_f && wr_n_f) begin
						bus_q <= spi_master_pkg::BUS_END;
					end
				end
				spi_master_pkg::BUS_END: begin
					if (ale_n_f) begin
						bus_q <= spi_master_pkg::BUS_IDLE;
					end
				end
				default: bus_q <= spi_master_pkg::BUS_IDLE;
			endcase
		end
	end

	// registers
	logic [7:0] ctrl_q;
	logic [7:0] ss_mask_q;
	logic [7:0] tx_hold_q;
	logic [7:0] rx_hold_q;
	logic       tx_empty_q;
	logic       rx_full_q;
	logic       err_q;
	logic       pending_q;
	logic       done_q;
	logic       ss_int_q;
	logic       wr_ctrl;
	logic       wr_tx;
	logic       rd_rx;
	logic       err_clr;
	logic       en;
	logic       start;
	logic [7:0] status;

	assign wr_ctrl = wr_commit && (addr_lo_q == `OFF_CONTROL);
	assign wr_tx   = wr_commit && (addr_lo_q == `OFF_TX_HOLD);
	assign rd_rx   = rd_commit && (addr_lo_q == `OFF_RX_HOLD);
	assign err_clr = wr_commit && (addr_lo_q == `OFF_STATUS) && !wdat_q[`ST_ERR];
	assign en      = ctrl_q[`CR_ENABLE];
	assign start   = ctrl_q[`CR_START];
	assign status  = {done_q, err_q, ss_int_q && !contention && (ss_mask_q != 8'h00), !pending_q,
		tx_empty_q, rx_full_q, 2'b00};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q    <= `REG_RESET;
			ss_mask_q <= `REG_RESET;
			tx_hold_q <= `REG_RESET;
		end else if (wr_commit) begin
			if (addr_lo_q == `OFF_CONTROL) begin
				ctrl_q <= wdat_q;
			end
			if (addr_lo_q == `OFF_SS_MASK) begin
				ss_mask_q <= wdat_q;
			end
			if (addr_lo_q == `OFF_TX_HOLD) begin
				tx_hold_q <= wdat_q;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ad_o <= `REG_RESET;
		end else begin
			unique case (addr_lo_q)
				`OFF_STATUS:  ad_o <= status;
				`OFF_CONTROL: ad_o <= ctrl_q;
				`OFF_SS_MASK: ad_o <= ss_mask_q;
				`OFF_TX_HOLD: ad_o <= tx_hold_q;
				`OFF_RX_HOLD: ad_o <= rx_hold_q;
				default:      ad_o <= `REG_RESET;
			endcase
		end
	end

	assign ad_oe_o = (bus_q == spi_master_pkg::BUS_XFER) && !is_wr_q;

	// serial clock divider: one tick per half period
	logic       eng_rst;
	logic [3:0] div_q;
	logic [3:0] half_m1;
	logic       tick;

	assign eng_rst = rst_i || !en || contention;
	always_comb begin
		unique case (ctrl_q[`CR_RATE_HI:`CR_RATE_LO])
			2'b00: half_m1 = 4'd1;
			2'b01: half_m1 = 4'd3;
			2'b10: half_m1 = 4'd7;
			2'b11: half_m1 = 4'd15;
		endcase
	end
	assign tick = (div_q >= half_m1);

	always_ff @(posedge clk_i) begin
		if (eng_rst) begin
			div_q <= 4'h0;
		end else begin
			div_q <= tick ? 4'h0 : div_q + 4'd1;
		end
	end

	// transfer engine
	spi_master_pkg::eng_state_type eng_q;
	logic [3:0] cnt_q;
	logic       sck_lvl_q;
	logic [7:0] tx_shift_q;
	logic [7:0] rx_shift_q;
	logic [7:0] rx_next;
	logic       sample;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic       setup_end;
	logic       byte_end;
	logic       go_on;
	logic       byte_load;
	logic       rx_load;
	logic       phase;

	assign phase     = ctrl_q[`CR_PHASE];
	assign setup_end = (eng_q == spi_master_pkg::ENG_SETUP) && tick && (cnt_q == `SETUP_TICKS - 4'd1);
	assign byte_end  = (eng_q == spi_master_pkg::ENG_XFER) && tick && (cnt_q == `LAST_EDGE);
	// select stays low between bytes only for phase one
	assign go_on     = start && phase && !tx_empty_q && fifo_in_ready;
	assign byte_load = setup_end || (byte_end && go_on);
	// outgoing edge lands on the chosen sample level
	assign sample    = (eng_q == spi_master_pkg::ENG_XFER) && tick
		&& ((!sck_lvl_q ^ ctrl_q[`CR_IDLE_LVL]) == ctrl_q[`CR_SAMPLE_EDGE]);
	assign rx_next   = sample ? {rx_shift_q[6:0], miso_f} : rx_shift_q;

	always_ff @(posedge clk_i) begin
		if (eng_rst) begin
			eng_q      <= spi_master_pkg::ENG_IDLE;
			cnt_q      <= 4'h0;
			sck_lvl_q  <= 1'b0;
			ss_int_q   <= 1'b0;
			tx_shift_q <= `REG_RESET;
			rx_shift_q <= `REG_RESET;
		end else begin
			rx_shift_q <= rx_next;
			unique case (eng_q)
				spi_master_pkg::ENG_IDLE: begin
					// a full fifo stalls the next byte
					if (start && !tx_empty_q && fifo_in_ready) begin
						ss_int_q <= 1'b1;
						cnt_q    <= 4'h0;
						eng_q    <= spi_master_pkg::ENG_SETUP;
					end
				end
				spi_master_pkg::ENG_SETUP: begin
					if (tick) begin
						cnt_q <= setup_end ? 4'h0 : cnt_q + 4'd1;
						if (setup_end) begin
							tx_shift_q <= tx_hold_q;
							eng_q      <= spi_master_pkg::ENG_XFER;
						end
					end
				end
				spi_master_pkg::ENG_XFER: begin
					if (tick) begin
						sck_lvl_q <= !sck_lvl_q;
						cnt_q     <= cnt_q + 4'd1;
						if (byte_end) begin
							cnt_q <= 4'h0;
							if (go_on) begin
								tx_shift_q <= tx_hold_q;
							end else begin
								eng_q <= spi_master_pkg::ENG_HOLD;
							end
						end else if (phase ? (!cnt_q[0] && cnt_q != 4'h0) : cnt_q[0]) begin
							tx_shift_q <= {tx_shift_q[6:0], 1'b0};
						end
					end
				end
				spi_master_pkg::ENG_HOLD: begin
					if (tick) begin
						cnt_q <= cnt_q + 4'd1;
						if (cnt_q == `HOLD_TICKS - 4'd1) begin
							cnt_q    <= 4'h0;
							ss_int_q <= 1'b0;
							eng_q    <= spi_master_pkg::ENG_GAP;
						end
					end
				end
				spi_master_pkg::ENG_GAP: begin
					if (tick) begin
						cnt_q <= cnt_q + 4'd1;
						if (cnt_q == `GAP_TICKS - 4'd1) begin
							eng_q <= spi_master_pkg::ENG_IDLE;
						end
					end
				end
				default: eng_q <= spi_master_pkg::ENG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (eng_rst) begin
			done_q <= 1'b0;
		end else if (byte_load) begin
			done_q <= 1'b0;
		end else if ((eng_q == spi_master_pkg::ENG_XFER) && tick && (cnt_q == `DONE_EDGE)) begin
			done_q <= 1'b1;
		end
	end

	byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i       (clk_i),
		.rst_i       (eng_rst),
		.in_valid_i  (byte_end),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (rx_next),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (!rx_full_q),
		.out_data_o  (fifo_out_data)
	);

	assign rx_load = fifo_out_valid && !rx_full_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_hold_q <= `REG_RESET;
			rx_full_q <= 1'b0;
		end else if (rx_load) begin
			rx_hold_q <= fifo_out_data;
			rx_full_q <= 1'b1;
		end else begin
			if (wr_commit && addr_lo_q == `OFF_RX_HOLD) begin
				rx_hold_q <= wdat_q;
			end
			if (rd_rx) begin
				rx_full_q <= 1'b0;
			end
		end
	end

	// a host write beats a same-cycle load: the new byte is still waiting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_empty_q <= 1'b0;
		end else if (wr_tx) begin
			tx_empty_q <= 1'b0;
		end else if (byte_load) begin
			tx_empty_q <= 1'b1;
		end
	end

	logic int_set;
	assign int_set = (byte_load && start) || (rx_load && !start) || contention;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_q     <= 1'b0;
			pending_q <= 1'b0;
		end else begin
			if (contention) begin
				err_q <= 1'b1;
			end else if (err_clr) begin
				err_q <= 1'b0;
			end
			if (int_set) begin
				pending_q <= 1'b1;
			end else if (wr_tx || rd_rx || err_clr) begin
				pending_q <= 1'b0;
			end
		end
	end

	assign irq_n_o            = !(en && ctrl_q[`CR_INT_GATE] && pending_q);
	assign tx_holding_empty_o = tx_empty_q;
	assign rx_holding_full_o  = rx_full_q;
	assign sck_o              = sck_lvl_q ^ ctrl_q[`CR_IDLE_LVL];
	assign mosi_o             = tx_shift_q[7];
	// selects drop together with the output enables, not one cycle after them
	assign ss_n_o             = ~(ss_mask_q & {8{ss_int_q && !contention}});
	assign sck_oe_o           = !contention;
	assign mosi_oe_o          = !contention;
	assign ss_oe_o            = !contention;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_load;
		byte_load;
	endsequence
	sequence s_shifting;
		!done_q [*1];
	endsequence

	property p_status_low;
		ad_oe_o && (addr_lo_q == `OFF_STATUS) && $stable(addr_lo_q) |-> ad_o[1:0] == 2'b00;
	endproperty
	a_status_low: assert property (p_status_low) else $error("status low bits not zero");
	property p_done_clear;
		s_load |=> s_shifting;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("done set at byte start");
	property p_err_set;
		contention |=> err_q;
	endproperty
	a_err_set: assert property (p_err_set) else $error("error flag missed contention");
	property p_release;
		contention |-> !sck_oe_o && !mosi_oe_o && !ss_oe_o && ss_n_o == 8'hff;
	endproperty
	a_release: assert property (p_release) else $error("spi pins driven under contention");
	property p_busy;
		status[`ST_BUSY] == (ss_n_o != 8'hff);
	endproperty
	a_busy: assert property (p_busy) else $error("busy bit disagrees with selects");
	property p_tx_write;
		wr_tx |=> !tx_holding_empty_o;
	endproperty
	a_tx_write: assert property (p_tx_write) else $error("tx empty not cleared by write");
	property p_rx_read;
		// a load in the same cycle wins over the read
		rd_rx && !rx_load |=> !rx_holding_full_o;
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("rx full not cleared by read");
	property p_irq;
		int_set && en && ctrl_q[`CR_INT_GATE] && !wr_ctrl |=> !irq_n_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt request not raised");
	property p_disabled;
		!en |=> ss_n_o == 8'hff && eng_q == spi_master_pkg::ENG_IDLE;
	endproperty
	a_disabled: assert property (p_disabled) else $error("engine active while disabled");
	property p_rate4;
		// a control write one cycle on may change the rate under the count
		tick && en && ctrl_q[`CR_RATE_HI:`CR_RATE_LO] == 2'b00 && !contention && !wr_ctrl ##1 !wr_ctrl
			|-> !tick ##1 (tick || contention || !en);
	endproperty
	a_rate4: assert property (p_rate4) else $error("divide by four half period wrong");
endmodule : spi_master_register_bank
`default_nettype wire

/* dv/spi_slave_model.sv */
// behavioural spi slave answering mode zero traffic on one select line
// assumes resolved bus wires from the bench: clock pulled down, selects pulled up
`timescale 1ns/1ps
`default_nettype none

module spi_slave_model (
	input  wire logic       sck_i,
	input  wire logic       ss_n_i,
	input  wire logic       mosi_i,
	input  wire logic [7:0] reply_i,
	output logic            miso_o,
	output logic [7:0]      got_o
);
	logic [7:0] shift_q;
	logic       last_q;

	initial begin
		shift_q = 8'h00;
		last_q = 1'b0;
		got_o = 8'h00;
	end

	always @(negedge ss_n_i) shift_q <= reply_i;
	always @(posedge ss_n_i) last_q <= shift_q[7];
	always @(posedge sck_i) if (!ss_n_i) got_o <= {got_o[6:0], mosi_i};
	always @(negedge sck_i) if (!ss_n_i) shift_q <= {shift_q[6:0], 1'b0};

	// released line shows the inverse of the last bit so a stale copy cannot pass
	assign miso_o = ss_n_i ? ~last_q : shift_q[7];
endmodule : spi_slave_model

`default_nettype wire

/* dv/spi_master_register_bank_tb.sv */
// self-checking bench for the spi master register bank
// assumes a mode zero slave model on select 0 and pulled bus lines
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_cfg.svh"

module spi_master_register_bank_tb;
	localparam logic [7:0] BASE = 8'h12;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  addr_hi = 8'h00;
	logic [7:0]  tb_ad = 8'h00;
	logic        tb_drv = 1'b0;
	logic        ale_n = 1'b1;
	logic        rd_n = 1'b1;
	logic        wr_n = 1'b1;
	logic        cont_n = 1'b1;
	logic [7:0]  cyc = 8'h00;
	wire  [7:0]  ad_w;
	wire  [7:0]  ad_o;
	wire         ad_oe;
	wire         irq_n;
	wire         txe;
	wire         rxf;
	wire         sck;
	wire         sck_oe;
	wire         mosi;
	wire         mosi_oe;
	wire         miso;
	wire  [7:0]  ss_n;
	wire         ss_oe;
	wire  [7:0]  got;
	int          fails = 0;
	int          check_count = 0;
	int          ticks = 0;
	logic [7:0]  rv;
	logic        hit;

	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 8'h01;

	// floating data bus gets a moving pattern so no old value survives
	assign ad_w = tb_drv ? tb_ad : (ad_oe ? ad_o : cyc);

	spi_master_register_bank #(.BASE_HI(BASE), .FIFO_DEPTH(8)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .addr_hi_i(addr_hi), .ad_i(ad_w), .ad_o(ad_o),
		.ad_oe_o(ad_oe), .ale_n_i(ale_n), .psen_n_i(1'b1), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.irq_n_o(irq_n), .tx_holding_empty_o(txe), .rx_holding_full_o(rxf), .sck_o(sck),
		.sck_oe_o(sck_oe), .mosi_o(mosi), .mosi_oe_o(mosi_oe), .miso_i(miso),
		.ss_n_o(ss_n), .ss_oe_o(ss_oe), .contention_n_i(cont_n)
	);

	spi_slave_model slave (
		.sck_i(sck_oe ? sck : 1'b0), .ss_n_i(ss_oe ? ss_n[0] : 1'b1),
		.mosi_i(mosi_oe ? mosi : ~mosi), .reply_i(8'h3c), .miso_o(miso), .got_o(got)
	);

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 60000) begin
			fails = fails + 1;
			conclude();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic clks(input int n);
		repeat (n) @(posedge clk_i);
	endtask : clks

	task automatic host_cycle(input logic [7:0] hi, input logic [7:0] a, input logic wr, input logic [7:0] d);
		addr_hi <= hi;
		tb_ad <= a;
		tb_drv <= 1'b1;
		ale_n <= 1'b0;
		clks(7);
		tb_drv <= wr;
		tb_ad <= d;
		if (wr) wr_n <= 1'b0;
		else rd_n <= 1'b0;
		hit = 1'b0;
		rv = 8'h00;
		for (int i = 0; i < 14 && !hit; i++) begin
			@(posedge clk_i);
			if (!wr && ad_oe === 1'b1) begin
				hit = 1'b1;
				rv = ad_w;
			end
		end
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		clks(8);
		tb_drv <= 1'b0;
		ale_n <= 1'b1;
		clks(7);
	endtask : host_cycle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_cycle(BASE, a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		host_cycle(BASE, a, 1'b0, 8'h00);
	endtask : rd

	// live values: a task input would only be a copy taken at the call
	function automatic logic [7:0] pick(input int sel);
		if (sel == 0) begin
			return {7'h00, rxf};
		end else if (sel == 1) begin
			return ss_n;
		end else if (sel == 2) begin
			return {7'h00, sck};
		end
		return {7'h00, txe};
	endfunction : pick

	task automatic wait_for(input int sel, input logic [7:0] e, input int lim);
		int n;
		logic [7:0] v;
		n = 0;
		v = pick(sel);
		while (v !== e && n < lim) begin
			@(posedge clk_i);
			n++;
			v = pick(sel);
		end
	endtask : wait_for

	task automatic t_reset;
		rd(`OFF_STATUS);
		chk(rv, 8'h10);
		rd(`OFF_CONTROL);
		chk(rv, `REG_RESET);
		chk(ss_n, 8'hff);
		chk({5'h00, irq_n, txe, rxf}, 8'h04);
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs;
		wr(`OFF_SS_MASK, 8'h5a);
		rd(`OFF_SS_MASK);
		chk(rv, 8'h5a);
		wr(`OFF_CONTROL, 8'h1e);
		rd(`OFF_CONTROL);
		chk(rv, 8'h1e);
		rd(8'h81);
		chk({7'h00, hit}, 8'h00);
		host_cycle(BASE + 8'h01, `OFF_CONTROL, 1'b0, 8'h00);
		chk({7'h00, hit}, 8'h00);
		wr(`OFF_CONTROL, 8'h00);
		$display("test registers done");
	endtask : t_regs

	task automatic t_xfer;
		rd(`OFF_STATUS);
		chk(rv & 8'h20, 8'h00);
		wr(`OFF_SS_MASK, 8'h01);
		wr(`OFF_TX_HOLD, 8'ha5);
		chk({7'h00, txe}, 8'h00);
		wr(`OFF_CONTROL, 8'hf1);
		while (txe !== 1'b1) @(posedge clk_i);
		chk(ss_n, 8'hfe);
		rd(`OFF_STATUS);
		chk(rv, 8'h28);
		chk({7'h00, irq_n}, 8'h00);
		wr(`OFF_CONTROL, 8'hd1);
		wait_for(0, 8'h01, 800);
		chk(got, 8'ha5);
		wr(`OFF_CONTROL, 8'h91);
		chk({7'h00, irq_n}, 8'h01);
		rd(`OFF_STATUS);
		chk(rv & 8'hdc, 8'h8c);
		wait_for(1, 8'hff, 400);
		rd(`OFF_STATUS);
		chk(rv & 8'h20, 8'h00);
		rd(`OFF_RX_HOLD);
		chk(rv, 8'h3c);
		rd(`OFF_STATUS);
		chk(rv & 8'h14, 8'h10);
		$display("test transfer done");
	endtask : t_xfer

	task automatic t_rates;
		int n;
		logic [7:0] cr;
		wr(`OFF_SS_MASK, 8'h81);
		for (int code = 0; code < 4; code++) begin
			cr = 8'h82 | 8'(code << 3);
			wr(`OFF_TX_HOLD, 8'(code));
			chk({7'h00, txe}, 8'h00);
			wr(`OFF_CONTROL, cr | 8'h20);
			// the byte may already be running: wait for a fresh falling edge
			wait_for(2, 8'h01, 800);
			wait_for(2, 8'h00, 800);
			chk(ss_n, 8'h7e);
			n = 0;
			while (sck === 1'b0 && n < 100) begin
				@(posedge clk_i);
				n++;
			end
			chk(8'(n), 8'(2 << code));
			wr(`OFF_CONTROL, cr);
			wait_for(1, 8'hff, 1200);
			chk({7'h00, sck}, 8'h01);
		end
		$display("test rates done");
	endtask : t_rates

	task automatic t_disable;
		wr(`OFF_SS_MASK, 8'h01);
		wr(`OFF_TX_HOLD, 8'h11);
		wr(`OFF_CONTROL, 8'h20);
		clks(100);
		chk(ss_n, 8'hff);
		chk({7'h00, txe}, 8'h00);
		$display("test disable done");
	endtask : t_disable

	task automatic t_contention;
		wr(`OFF_CONTROL, 8'he1);
		wait_for(1, 8'hfe, 100);
		cont_n <= 1'b0;
		clks(8);
		chk({5'h00, sck_oe, mosi_oe, ss_oe}, 8'h00);
		chk({7'h00, irq_n}, 8'h00);
		cont_n <= 1'b1;
		clks(8);
		rd(`OFF_STATUS);
		chk(rv & 8'h40, 8'h40);
		wr(`OFF_STATUS, 8'h00);
		rd(`OFF_STATUS);
		chk(rv & 8'h40, 8'h00);
		wr(`OFF_CONTROL, 8'h80);
		$display("test contention done");
	endtask : t_contention

	// idle high, phase one: slave samples rising edges, bytes run back to back
	task automatic t_phase;
		wr(`OFF_SS_MASK, 8'h01);
		wr(`OFF_TX_HOLD, 8'hb4);
		wr(`OFF_CONTROL, 8'haf);
		wait_for(3, 8'h01, 400);
		wr(`OFF_TX_HOLD, 8'h69);
		wait_for(3, 8'h01, 400);
		chk(ss_n, 8'hfe);
		chk(got, 8'hb4);
		wr(`OFF_CONTROL, 8'h8f);
		wait_for(1, 8'hff, 400);
		chk(got, 8'h69);
		$display("test phase one done");
	endtask : t_phase

	initial begin
		clks(16);
		rst_i <= 1'b0;
		clks(8);
		t_reset();
		t_regs();
		t_xfer();
		t_rates();
		t_disable();
		t_contention();
		t_phase();
		conclude();
	end
endmodule : spi_master_register_bank_tb

`default_nettype wire
